// ### hdl/pal_port_a_io_latch.sv
`timescale 1ns/1ns
module pal_port_a_io_latch (
   input wire logic clk_sys, // core clock, 10 MHz
   input wire logic srst, // synchronous reset, active high
   input wire pal_pkg::pal_bus_req_s bus_req, // internal data bus request
   output logic [7:0] rdata_reg, // read data, one cycle after rd
   input wire pal_pkg::pal_mode_e mode, // processor mode from configuration bits
   output logic sysbus_sel_reg, // bus-capable ports act as system bus
   input wire logic [5:0] pa_pin_in, // first port pin levels
   output logic [5:0] pa_pin_out, // first port pin drive value
   output logic [5:0] pa_pin_oe, // first port pin drive enable
   input wire pal_pkg::pal_alt_s pa_alt, // peripheral claim on first port
   output logic [5:0] pa_periph_in, // synchronised pin levels to peripherals
   input wire logic [7:0] pb_pin_in, // second port pin levels
   output logic [7:0] pb_pin_out, // second port pin drive value
   output logic [7:0] pb_pin_oe, // second port pin drive enable
   input wire pal_pkg::pal_alt_s pb_alt, // peripheral claim on second port
   output logic [7:0] pb_periph_in, // synchronised pin levels to peripherals
   output logic [7:0] pb_pullup_en // weak pull-up enable per pin
);
   import pal_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [1:0] pa_latch_reg;
   logic [1:0] pa_latch_next;
   logic pullup_off_reg;
   logic pullup_off_next;
   logic [7:0] pb_latch_reg;
   logic [7:0] pb_latch_next;
   logic [7:0] pb_dir_reg;
   logic [7:0] pb_dir_next;
   logic [5:0] pa_meta_reg;
   logic [5:0] pa_sync_reg;
   logic [7:0] pb_meta_reg;
   logic [7:0] pb_sync_reg;
   logic [7:0] rdata_next;
   logic sysbus_sel_next;
   logic [5:0] pa_out_next;
   logic [5:0] pa_oe_next;
   logic [5:0] pa_periph_next;
   logic [7:0] pb_out_next;
   logic [7:0] pb_oe_next;
   logic [7:0] pb_periph_next;
   logic [7:0] pb_pullup_next;
   logic bank_hit;

   // ------------------------------------------------------------
   // register access
   // ------------------------------------------------------------
   always_comb
   begin
      pa_latch_next = pa_latch_reg;
      pullup_off_next = pullup_off_reg;
      pb_latch_next = pb_latch_reg;
      pb_dir_next = pb_dir_reg;
      rdata_next = PAL_READ_NONE;
      bank_hit = (bus_req.bank == PAL_BANK_ZERO);
      if (bus_req.wr && bank_hit)
      begin
         unique case (bus_req.addr)
            PAL_FIRST_PORT_ADDR:
            begin
               // only the open-drain latch bits and the pull-up bit are stored
               pa_latch_next = bus_req.wdata[3:2];
               pullup_off_next = bus_req.wdata[PAL_PULLUP_OFF_BIT];
            end
            PAL_SECOND_DIR_ADDR: pb_dir_next = bus_req.wdata;
            PAL_SECOND_PORT_ADDR: pb_latch_next = bus_req.wdata;
            default: ;
         endcase
      end
      if (bus_req.rd && bank_hit)
      begin
         unique case (bus_req.addr)
            // pins, not latch; unimplemented bit six reads zero
            PAL_FIRST_PORT_ADDR: rdata_next = {pullup_off_reg, 1'b0, pa_sync_reg};
            PAL_SECOND_DIR_ADDR: rdata_next = pb_dir_reg;
            PAL_SECOND_PORT_ADDR: rdata_next = pb_sync_reg;
            default: rdata_next = PAL_READ_NONE;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         pa_latch_reg <= PAL_OPEN_DRAIN_RESET;
         pullup_off_reg <= PAL_PULLUP_OFF_RESET;
         pb_latch_reg <= 8'h00;
         pb_dir_reg <= PAL_DIR_RESET;
         rdata_reg <= PAL_READ_NONE;
      end
      else
      begin
         pa_latch_reg <= pa_latch_next;
         pullup_off_reg <= pullup_off_next;
         pb_latch_reg <= pb_latch_next;
         pb_dir_reg <= pb_dir_next;
         rdata_reg <= rdata_next;
      end
   end

   // ------------------------------------------------------------
   // pin input synchronisers
   // ------------------------------------------------------------
   // every pin is sampled even while driven, so reads and peripherals see the real pad
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         pa_meta_reg <= 6'h00;
         pa_sync_reg <= 6'h00;
         pb_meta_reg <= 8'h00;
         pb_sync_reg <= 8'h00;
      end
      else
      begin
         pa_meta_reg <= pa_pin_in;
         pa_sync_reg <= pa_meta_reg;
         pb_meta_reg <= pb_pin_in;
         pb_sync_reg <= pb_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------
   always_comb
   begin
      // pins zero and one are inputs only; they feed interrupt and timer
      pa_out_next = 6'h00;
      pa_oe_next = 6'h00;
      // open drain: drive low only, never high
      if (pa_alt.en[2] || pa_alt.en[3])
      begin
         pa_oe_next[2] = pa_alt.en[2] ? (pa_alt.oe[2] && !pa_alt.drv[2]) : !pa_latch_reg[0];
         pa_oe_next[3] = pa_alt.en[3] ? (pa_alt.oe[3] && !pa_alt.drv[3]) : !pa_latch_reg[1];
      end
      else
      begin
         pa_oe_next[2] = !pa_latch_reg[0];
         pa_oe_next[3] = !pa_latch_reg[1];
      end
      // transceiver owns pins four and five, floats when disabled
      pa_out_next[5:4] = pa_alt.drv[5:4];
      pa_oe_next[5:4] = pa_alt.en[5:4] & pa_alt.oe[5:4];
      // the driven level comes back through the pad, so peripherals see it
      pa_periph_next = pa_sync_reg;
      pb_periph_next = pb_sync_reg;
      // the direction bit is left alone while a peripheral holds the pin
      pb_out_next = (pb_alt.en & pb_alt.drv) | (~pb_alt.en & pb_latch_reg);
      pb_oe_next = (pb_alt.en & pb_alt.oe) | (~pb_alt.en & ~pb_dir_reg);
      // pull-ups follow the control bit and drop on driven pins
      pb_pullup_next = {8{!pullup_off_reg}} & ~pb_oe_next;
      sysbus_sel_next = (mode == PAL_MODE_EXTENDED) || (mode == PAL_MODE_PROCESSOR);
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         // all pins float and the transceiver is released during reset
         pa_pin_out <= 6'h00;
         pa_pin_oe <= 6'h00;
         pa_periph_in <= 6'h00;
         pb_pin_out <= 8'h00;
         pb_pin_oe <= 8'h00;
         pb_periph_in <= 8'h00;
         pb_pullup_en <= 8'hff;
         sysbus_sel_reg <= 1'b0;
      end
      else
      begin
         pa_pin_out <= pa_out_next;
         pa_pin_oe <= pa_oe_next;
         pa_periph_in <= pa_periph_next;
         pb_pin_out <= pb_out_next;
         pb_pin_oe <= pb_oe_next;
         pb_periph_in <= pb_periph_next;
         pb_pullup_en <= pb_pullup_next;
         sysbus_sel_reg <= sysbus_sel_next;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_first_write;
      bus_req.wr && bus_req.bank == PAL_BANK_ZERO && bus_req.addr == PAL_FIRST_PORT_ADDR && !pa_alt.en[2];
   endsequence

   // one edge after the write latch bit zero and the pull-up bit must match what was written, or the assertion fails
   sequence s_latched;
      pa_latch_reg[0] == $past(bus_req.wdata[2]) && pullup_off_reg == $past(bus_req.wdata[PAL_PULLUP_OFF_BIT]);
   endsequence

   property p_write_drives;
      @(posedge clk_sys) disable iff (srst)
      s_first_write ##1 (!pa_alt.en[2]) |-> s_latched ##1 (pa_pin_oe[2] == !$past(bus_req.wdata[2], 2));
   endproperty
   a_write_drives: assert property (p_write_drives) else $error("open-drain latch write not driven");

   property p_reset_floats;
      @(posedge clk_sys) srst |=> pa_pin_oe == 6'h00 && pb_pin_oe == 8'h00 && pb_dir_reg == 8'hff;
   endproperty
   a_reset_floats: assert property (p_reset_floats) else $error("pins not floated by reset");

   property p_reset_value;
      @(posedge clk_sys) srst |=> pa_latch_reg == 2'h3 && !pullup_off_reg;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("first port reset value wrong");

   property p_read_pins;
      @(posedge clk_sys) disable iff (srst)
      bus_req.rd && bus_req.bank == PAL_BANK_ZERO && bus_req.addr == PAL_FIRST_PORT_ADDR
      |=> rdata_reg == {$past(pullup_off_reg), 1'b0, $past(pa_sync_reg)};
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("first port read not pin levels");

   property p_low_pins_input;
      @(posedge clk_sys) disable iff (srst) pa_pin_oe[1:0] == 2'h0 && pa_pin_out[3:2] == 2'h0;
   endproperty
   a_low_pins_input: assert property (p_low_pins_input) else $error("input-only or open-drain pin misdriven");

   property p_serial_release;
      @(posedge clk_sys) disable iff (srst) !pa_alt.en[4] && !pa_alt.en[5] |=> pa_pin_oe[5:4] == 2'h0;
   endproperty
   a_serial_release: assert property (p_serial_release) else $error("disabled transceiver still drives");

   property p_override;
      @(posedge clk_sys) disable iff (srst) pb_alt.en[0] |=> pb_pin_oe[0] == $past(pb_alt.oe[0]);
   endproperty
   a_override: assert property (p_override) else $error("peripheral did not take pin");

   property p_direction;
      @(posedge clk_sys) disable iff (srst) !pb_alt.en[1] |=> pb_pin_oe[1] == !$past(pb_dir_reg[1]);
   endproperty
   a_direction: assert property (p_direction) else $error("direction bit sense wrong");

   property p_pullup;
      @(posedge clk_sys) disable iff (srst)
      pb_pullup_en[0] |-> !pb_pin_oe[0] && !$past(pullup_off_reg);
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up enabled against control");

   property p_sync_path;
      @(posedge clk_sys) disable iff (srst)
      !$past(srst) && !$past(srst, 2) && !$past(srst, 3) |-> pa_periph_in == $past(pa_pin_in, 3);
   endproperty
   a_sync_path: assert property (p_sync_path) else $error("pin sample path not three cycles");

   property p_sysbus;
      @(posedge clk_sys) disable iff (srst)
      mode == PAL_MODE_PROCESSOR || mode == PAL_MODE_EXTENDED |=> sysbus_sel_reg;
   endproperty
   a_sysbus: assert property (p_sysbus) else $error("system bus not selected");

endmodule // pal_port_a_io_latch

// ### common/pal_pkg.sv
package pal_pkg;

   // ------------------------------------------------------------
   // register map, bank zero
   // ------------------------------------------------------------
   localparam logic [3:0] PAL_BANK_ZERO = 4'h0;
   localparam logic [7:0] PAL_FIRST_PORT_ADDR = 8'h10;
   localparam logic [7:0] PAL_SECOND_DIR_ADDR = 8'h11;
   localparam logic [7:0] PAL_SECOND_PORT_ADDR = 8'h12;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int PAL_PULLUP_OFF_BIT = 7;
   localparam int PAL_FIRST_WIDTH = 6;
   localparam int PAL_SECOND_WIDTH = 8;
   localparam logic [1:0] PAL_OPEN_DRAIN_RESET = 2'h3;
   localparam logic PAL_PULLUP_OFF_RESET = 1'b0;
   localparam logic [7:0] PAL_DIR_RESET = 8'hff;
   localparam logic [7:0] PAL_READ_NONE = 8'h00;

   // configuration-bit processor modes
   typedef enum logic [1:0] {
      PAL_MODE_MICRO = 2'h0,
      PAL_MODE_PROTECTED = 2'h1,
      PAL_MODE_EXTENDED = 2'h3,
      PAL_MODE_PROCESSOR = 2'h2
   } pal_mode_e;

   // internal data bus access, one cycle per request
   typedef struct packed {
      logic [3:0] bank;
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } pal_bus_req_s;

   // peripheral claim on shared pins, one bit per pin
   typedef struct packed {
      logic [7:0] en;
      logic [7:0] drv;
      logic [7:0] oe;
   } pal_alt_s;

endpackage

// ### bench/pal_board_model.sv
`timescale 1ns/1ns
module pal_board_model (
   input wire logic [5:0] pa_pin_out, // first port drive value
   input wire logic [5:0] pa_pin_oe, // first port drive enable
   input wire logic [5:0] pa_ext, // board level on undriven first-port pads other than pins two and three
   input wire logic [7:0] pb_pin_out, // second port drive value
   input wire logic [7:0] pb_pin_oe, // second port drive enable
   input wire logic [7:0] pb_pullup_en, // weak pull-up enable
   input wire logic [7:0] pb_ext, // board level on undriven second-port pads with the pull-up off
   output logic [5:0] pa_pin_in, // resolved first port pads
   output logic [7:0] pb_pin_in // resolved second port pads
);
   // ------------------------------------------------------------
   // pad resolution
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         if (pa_pin_oe[i])
            pa_pin_in[i] = (i == 2 || i == 3) ? 1'b0 : pa_pin_out[i];
         else if (i == 2 || i == 3)
            pa_pin_in[i] = 1'b1; // external resistor lifts released open drain
         else
            pa_pin_in[i] = pa_ext[i];
      end
      for (int i = 0; i < 8; i++)
      begin
         if (pb_pin_oe[i])
            pb_pin_in[i] = pb_pin_out[i];
         else if (pb_pullup_en[i])
            pb_pin_in[i] = 1'b1;
         else
            pb_pin_in[i] = pb_ext[i];
      end
   end
endmodule // pal_board_model

// ### bench/pal_port_a_io_latch_tb.sv
`timescale 1ns/1ns
module pal_port_a_io_latch_tb;
   import pal_pkg::*;
   logic clk_sys = 0, srst = 1;
   pal_bus_req_s bus_req = '0;
   pal_mode_e mode = PAL_MODE_MICRO;
   pal_alt_s pa_alt = '0, pb_alt = '0;
   logic [5:0] pa_ext = 6'h21;
   logic [7:0] pb_ext = 8'h00;
   logic [7:0] rdata_reg, pb_pin_in, pb_pin_out, pb_pin_oe, pb_periph_in, pb_pullup_en, rd_val;
   logic [5:0] pa_pin_in, pa_pin_out, pa_pin_oe, pa_periph_in;
   logic sysbus_sel_reg;
   int fails = 0, comparisons = 0;
   always #50 clk_sys = ~clk_sys;
   pal_port_a_io_latch uut (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req), .rdata_reg(rdata_reg),
      .mode(mode), .sysbus_sel_reg(sysbus_sel_reg), .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out),
      .pa_pin_oe(pa_pin_oe), .pa_alt(pa_alt), .pa_periph_in(pa_periph_in), .pb_pin_in(pb_pin_in),
      .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe), .pb_alt(pb_alt), .pb_periph_in(pb_periph_in),
      .pb_pullup_en(pb_pullup_en));
   pal_board_model board (.pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pa_ext(pa_ext),
      .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe), .pb_pullup_en(pb_pullup_en), .pb_ext(pb_ext),
      .pa_pin_in(pa_pin_in), .pb_pin_in(pb_pin_in));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys) bus_req = '{b, a, 1'b1, 1'b0, d};
      @(negedge clk_sys) bus_req = '0;
   endtask
   task automatic rd(input logic [3:0] b, input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys) bus_req = '{b, a, 1'b0, 1'b1, 8'h00};
      @(negedge clk_sys) bus_req = '0;
      d = rdata_reg;
   endtask
   task automatic settle();
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial
   begin
      repeat (4) @(negedge clk_sys);
      srst = 0;
      settle();
      chk({2'b00, pa_pin_oe}, 8'h00);
      chk(pb_pullup_en, 8'hff);
      rd(PAL_BANK_ZERO, PAL_FIRST_PORT_ADDR, rd_val); chk(rd_val, 8'h2d);
      rd(PAL_BANK_ZERO, PAL_SECOND_DIR_ADDR, rd_val); chk(rd_val, 8'hff);
      wr(PAL_BANK_ZERO, PAL_FIRST_PORT_ADDR, 8'h00); settle();
      chk({2'b00, pa_pin_oe}, 8'h0c);
      chk({2'b00, pa_pin_out}, 8'h00);
      rd(PAL_BANK_ZERO, PAL_FIRST_PORT_ADDR, rd_val); chk(rd_val, 8'h21);
      wr(PAL_BANK_ZERO, PAL_FIRST_PORT_ADDR, 8'hf3); settle();
      chk(pb_pullup_en, 8'h00);
      rd(PAL_BANK_ZERO, PAL_FIRST_PORT_ADDR, rd_val); chk(rd_val, 8'ha1);
      wr(PAL_BANK_ZERO, PAL_FIRST_PORT_ADDR, 8'h0c); settle();
      chk({2'b00, pa_pin_oe}, 8'h00);
      chk(pb_pullup_en, 8'hff);
      // second port: two outputs, one driven high, one low
      wr(PAL_BANK_ZERO, PAL_SECOND_DIR_ADDR, 8'hcf);
      wr(PAL_BANK_ZERO, PAL_SECOND_PORT_ADDR, 8'h10); settle();
      chk(pb_pin_oe, 8'h30);
      chk(pb_pin_out, 8'h10);
      chk(pb_pullup_en, 8'hcf);
      chk(pb_periph_in, 8'hdf);
      rd(PAL_BANK_ZERO, PAL_SECOND_DIR_ADDR, rd_val); chk(rd_val, 8'hcf);
      rd(PAL_BANK_ZERO, PAL_SECOND_PORT_ADDR, rd_val); chk(rd_val, 8'hdf);
      // access outside bank zero or the map is ignored
      wr(4'h1, PAL_SECOND_DIR_ADDR, 8'h00);
      rd(PAL_BANK_ZERO, PAL_SECOND_DIR_ADDR, rd_val); chk(rd_val, 8'hcf);
      rd(4'h1, PAL_FIRST_PORT_ADDR, rd_val); chk(rd_val, PAL_READ_NONE);
      rd(PAL_BANK_ZERO, 8'h13, rd_val); chk(rd_val, PAL_READ_NONE);
      // peripherals claim shared pins
      @(negedge clk_sys);
      pa_alt = '{8'h3c, 8'h24, 8'h3c};
      pb_alt = '{8'h05, 8'h04, 8'h05};
      pa_ext = 6'h02;
      settle();
      chk({2'b00, pa_pin_oe}, 8'h38);
      chk({2'b00, pa_pin_out}, 8'h20);
      chk(pb_pin_oe, 8'h35);
      chk(pb_pin_out, 8'h14);
      chk({2'b00, pa_periph_in}, 8'h26);
      // processor modes
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk_sys) mode = pal_mode_e'(i[1:0]);
         settle();
         chk({7'h00, sysbus_sel_reg}, {7'h00, i[1]});
      end
      // reset with peripherals still claiming pins
      @(negedge clk_sys) srst = 1;
      repeat (2) @(negedge clk_sys);
      chk({2'b00, pa_pin_oe}, 8'h00);
      chk(pb_pin_oe, 8'h00);
      chk(pb_pullup_en, 8'hff);
      pa_alt = '0;
      pb_alt = '0;
      @(negedge clk_sys) srst = 0;
      settle();
      rd(PAL_BANK_ZERO, PAL_SECOND_DIR_ADDR, rd_val); chk(rd_val, 8'hff);
      chk(pb_pin_oe, 8'h00);
      // reset loaded the all-input direction, so software puts its own direction back
      wr(PAL_BANK_ZERO, PAL_SECOND_DIR_ADDR, 8'hcf); settle();
      chk(pb_pin_oe, 8'h30);
      wrap_up();
   end
   initial
   begin
      #(400 * 100);
      fails++;
      wrap_up();
   end
endmodule // pal_port_a_io_latch_tb
